// file: rtl/lprs_pkg.sv
// Constants, register map and state codes of the low-power and reset status block
// Contract
// (RULE1) Wait/stop instruction enters low power, CPU unclocked
// (RULE2) Entering wait or stop clears interrupt mask
// (RULE3) Wait stops CPU clock, peripherals keep running
// (RULE4) Enabled peripheral interrupt wakes CPU from wait
// (RULE5) Wait wake stacking starts one cycle later
// (RULE6) Reset or emulation break ends wait; sets flag
// (RULE7) Watchdog runs in wait unless disabled
// (RULE8) Stop resets system counter, gates both oscillator clocks
// (RULE9) Stop ends on interrupt, reset, break; delayed stacking
// (RULE10) Recovery 4096 quad clocks, or 32 when short
// (RULE11) Crystal systems should keep short recovery clear
// (RULE12) Reading reset-source status clears its flags
// (RULE13) Power-on sets its flag, clears all others
// (RULE14) Other resets set own flag only
// (RULE15) External pin reset sets pin flag
// (RULE16) Watchdog reset sets watchdog flag
// (RULE17) Illegal opcode reset sets bad-opcode flag
// (RULE18) Bad fetch address reset sets its flag
// (RULE19) Monitor entry reset sets monitor flag
// (RULE20) Low-voltage reset sets low-voltage flag
// (RULE21) In break, flags clearable only when enabled; only the two-step clear is gated, reset-source reads still clear in break
// (RULE22) Two-step clear stays protected through break
// (RULE23) Clearing read returns flags before clear
`default_nettype none

package lprs_pkg;
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 32;
  // Register byte offsets
  localparam logic [7:0]  OFS_RSR       = 8'h00;
  localparam logic [7:0]  OFS_BFC       = 8'h04;
  localparam logic [7:0]  OFS_BSR       = 8'h08;
  localparam logic [7:0]  OFS_CFG       = 8'h0c;
  // Reset-source flag positions
  localparam int unsigned SRC_N         = 7;
  localparam int unsigned BIT_POR       = 0;
  localparam int unsigned BIT_PIN       = 1;
  localparam int unsigned BIT_WDOG      = 2;
  localparam int unsigned BIT_OPC       = 3;
  localparam int unsigned BIT_FETCH     = 4;
  localparam int unsigned BIT_MON       = 5;
  localparam int unsigned BIT_LVR       = 6;
  localparam logic [6:0]  RSR_RESET     = 7'h01;
  // Control and status fields
  localparam int unsigned BFC_CLR_EN    = 0;
  localparam logic        BFC_RESET     = 1'b0;
  localparam int unsigned BSR_BSW       = 0;
  localparam int unsigned CFG_WDOG_DIS  = 0;
  localparam int unsigned CFG_SHORT_REC = 1;
  localparam logic [1:0]  CFG_RESET     = 2'h0;
  // Stop recovery, in quadruple-rate oscillator cycles
  localparam int unsigned RECOV_LONG    = 4096;
  localparam int unsigned RECOV_SHORT   = 32;
  localparam int unsigned REC_W         = 13;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_WAIT  = 2'b01,
    ST_STOP  = 2'b10,
    ST_RECOV = 2'b11
  } lprs_state_t;
endpackage : lprs_pkg

`default_nettype wire

// file: rtl/lprs_rec_if.sv
// Handshake between the sequencer and its stop recovery counter
`default_nettype none

interface lprs_rec_if;
  logic start;
  logic short_sel;
  logic tick;
  logic done;
  logic busy;
  modport ctrl (output start, output short_sel, output tick, input done, input busy);
  modport cnt  (input start, input short_sel, input tick, output done, output busy);
endinterface : lprs_rec_if

`default_nettype wire

// file: rtl/lprs_recovery.sv
// Stop recovery delay counter on quadruple-rate oscillator ticks
`default_nettype none

module lprs_recovery
  import lprs_pkg::*;
#(
  parameter int unsigned LONG_CNT  = RECOV_LONG,
  parameter int unsigned SHORT_CNT = RECOV_SHORT
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  lprs_rec_if.cnt   rec
);
  localparam logic [REC_W-1:0] LAST_L = REC_W'(LONG_CNT - 1);
  localparam logic [REC_W-1:0] LAST_S = REC_W'(SHORT_CNT - 1);

  logic [REC_W-1:0] cnt_q;
  logic [REC_W-1:0] last_q;
  logic             busy_q;
  logic             done_q;

  assign rec.busy = busy_q;
  assign rec.done = done_q;

  // A new start restarts, so a stale count cannot end it early
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= '0;
      last_q <= LAST_L;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (clk_en) begin
      done_q <= 1'b0;
      if (rec.start) begin
        cnt_q  <= '0;
        last_q <= rec.short_sel ? LAST_S : LAST_L; // RULE10
        busy_q <= 1'b1;
      end else if (busy_q && rec.tick) begin
        if (cnt_q == last_q) begin
          busy_q <= 1'b0;
          done_q <= 1'b1; // RULE10
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end
endmodule : lprs_recovery

`default_nettype wire

// file: rtl/lprs_top.sv
// Low-power sequencer with reset-source status and break flag control
//
// Register access over APB and the register offsets were left to the implementer.
`default_nettype none

module lprs_top
  import lprs_pkg::*;
#(
  parameter int unsigned IRQ_N     = 8,
  parameter int unsigned LONG_CNT  = RECOV_LONG,
  parameter int unsigned SHORT_CNT = RECOV_SHORT
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              wait_instr,
  input  wire logic              stop_instr,
  input  wire logic [IRQ_N-1:0]  irq_req,
  input  wire logic [IRQ_N-1:0]  irq_en,
  input  wire logic              brk_req,
  input  wire logic              brk_done,
  input  wire logic              emul_mode,
  input  wire logic              quad_osc_tick,
  input  wire logic [SRC_N-1:0]  rst_src,
  input  wire logic              step1_pulse,
  input  wire logic              step2_pulse,
  output logic                   cpu_clk_en,
  output logic                   per_clk_en,
  output logic                   dbl_osc_clk_en,
  output logic                   quad_osc_clk_en,
  output logic                   imask_clr,
  output logic                   stack_start,
  output logic                   sys_cnt_rst,
  output logic                   watchdog_run,
  output logic                   break_active,
  output logic                   flag_clear_ok,
  output logic                   two_step_clear,
  output logic [1:0]             low_power_state
);
  import lprs_pkg::*;

  // ------------------------------
  // Declarations
  // ------------------------------
  lprs_state_t      state_q;
  lprs_state_t      state_d;
  lprs_rec_if       rec ();

  logic [SRC_N-1:0] src_s1_q;
  logic [SRC_N-1:0] src_s2_q;
  logic [SRC_N-1:0] src_s3_q;
  logic [SRC_N-1:0] src_evt;
  logic             rst_evt;

  logic [SRC_N-1:0] rsr_q;
  logic [SRC_N-1:0] rsr_clr;
  logic             break_clear_enable_q;
  logic             bsw_q;
  logic [1:0]       cfg_q;
  logic             break_q;
  logic             armed_q;

  logic [DATA_W-1:0] prdata_q;
  logic              pready_q;
  logic              pslverr_q;
  logic              apb_acc;
  logic              apb_cap;
  logic              apb_done;
  logic              apb_wr;
  logic [DATA_W-1:0] rd_data;
  logic              rd_hit;

  logic irq_hit;
  logic brk_take;
  logic clear_ok;
  logic enter_lp;
  logic enter_stop;
  logic wake_wait;
  logic wake_stop;
  logic brk_exit;
  logic rec_fin;
  logic wake_pend_q;
  logic rec_start_q;

  logic cpu_clk_en_q;
  logic per_clk_en_q;
  logic osc_en_q;
  logic imask_clr_q;
  logic stack_start_q;
  logic sys_cnt_rst_q;
  logic watchdog_run_q;
  logic flag_clear_ok_q;
  logic two_step_clear_q;

  // ------------------------------
  // Helpers
  // ------------------------------
  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    addr_is = (a == ofs);
  endfunction : addr_is

  function automatic logic [DATA_W-1:0] pad_low(input logic [7:0] v);
    pad_low = {{(DATA_W-8){1'b0}}, v};
  endfunction : pad_low

  // ------------------------------
  // Reset-source pins
  // ------------------------------
  // Sources come from pads and analog detectors, so they are synchronised
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_s1_q <= '0;
      src_s2_q <= '0;
      src_s3_q <= '0;
    end else if (clk_en) begin
      src_s1_q <= rst_src;
      src_s2_q <= src_s1_q;
      src_s3_q <= src_s2_q;
    end
  end

  assign src_evt = src_s2_q & ~src_s3_q;
  assign rst_evt = |src_evt;

  // ------------------------------
  // Reset-source status flags
  // ------------------------------
  // Only the bits that the read returned are cleared, so a source that
  // fires during the access survives into the next read
  assign rsr_clr = (apb_done && !pwrite && addr_is(paddr, OFS_RSR)) ?
                   prdata_q[SRC_N-1:0] : '0; // RULE12 RULE23

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsr_q <= RSR_RESET; // RULE13
    end else if (clk_en) begin
      if (src_evt[BIT_POR]) begin
        rsr_q <= src_evt; // RULE13
      end else begin
        // Set wins over the clearing read
        rsr_q <= (rsr_q & ~rsr_clr) | src_evt; // RULE14 RULE15 RULE16 RULE17 RULE18 RULE19 RULE20
      end
    end
  end

  // ------------------------------
  // Software control registers
  // ------------------------------
  assign apb_wr = apb_done && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_clear_enable_q <= BFC_RESET;
    end else if (clk_en && apb_wr && addr_is(paddr, OFS_BFC)) begin
      break_clear_enable_q <= pwdata[BFC_CLR_EN]; // RULE21
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= CFG_RESET;
    end else if (clk_en && apb_wr && addr_is(paddr, OFS_CFG)) begin
      cfg_q <= pwdata[1:0];
    end
  end

  // Break-during-low-power flag: write one to clear, a new break wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bsw_q <= 1'b0;
    end else if (clk_en) begin
      if (brk_exit) begin
        bsw_q <= 1'b1; // RULE6
      end else if (apb_wr && addr_is(paddr, OFS_BSR) && pwdata[BSR_BSW]) begin
        bsw_q <= 1'b0;
      end
    end
  end

  // ------------------------------
  // APB slave
  // ------------------------------
  // One wait state: data is captured in the first access cycle
  assign apb_acc  = psel && penable;
  assign apb_cap  = apb_acc && !pready_q;
  assign apb_done = apb_acc && pready_q;

  always_comb begin
    rd_data = '0;
    rd_hit  = 1'b1;
    if (addr_is(paddr, OFS_RSR)) begin
      rd_data = pad_low({1'b0, rsr_q}); // RULE23
    end else if (addr_is(paddr, OFS_BFC)) begin
      rd_data = pad_low({7'h00, break_clear_enable_q});
    end else if (addr_is(paddr, OFS_BSR)) begin
      rd_data = pad_low({7'h00, bsw_q});
    end else if (addr_is(paddr, OFS_CFG)) begin
      rd_data = pad_low({6'h00, cfg_q});
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else if (clk_en) begin
      pready_q  <= apb_cap;
      pslverr_q <= apb_cap && !rd_hit;
      if (apb_cap) begin
        prdata_q <= pwrite ? '0 : rd_data;
      end
    end
  end

  // ------------------------------
  // Break tracking and flag protection
  // ------------------------------
  // Outside emulation a break cannot pull the core out of wait
  assign brk_take = brk_req && (state_q != ST_WAIT || emul_mode); // RULE6
  assign clear_ok = !break_q || break_clear_enable_q; // RULE21

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_q <= 1'b0;
    end else if (clk_en) begin
      if (brk_take) begin
        break_q <= 1'b1;
      end else if (brk_done) begin
        break_q <= 1'b0;
      end
    end
  end

  // The first step is remembered across break; only the second is gated
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_q <= 1'b0;
    end else if (clk_en) begin
      if (step1_pulse) begin
        armed_q <= 1'b1; // RULE22
      end else if (step2_pulse && clear_ok) begin
        armed_q <= 1'b0; // RULE22
      end
    end
  end

  // ------------------------------
  // Low-power state machine
  // ------------------------------
  assign irq_hit = |(irq_req & irq_en); // RULE4 RULE9

  always_comb begin
    state_d    = state_q;
    enter_lp   = 1'b0;
    enter_stop = 1'b0;
    wake_wait  = 1'b0;
    wake_stop  = 1'b0;
    brk_exit   = 1'b0;
    rec_fin    = 1'b0;
    case (state_q)
      ST_RUN: begin
        if (stop_instr) begin
          state_d    = ST_STOP; // RULE1
          enter_lp   = 1'b1;
          enter_stop = 1'b1;
        end else if (wait_instr) begin
          state_d  = ST_WAIT; // RULE1
          enter_lp = 1'b1;
        end
      end
      ST_WAIT: begin
        if (rst_evt) begin
          state_d = ST_RUN; // RULE6
        end else if (brk_take) begin
          state_d  = ST_RUN; // RULE6
          brk_exit = 1'b1;
        end else if (irq_hit) begin
          state_d   = ST_RUN; // RULE4
          wake_wait = 1'b1;
        end
      end
      ST_STOP: begin
        if (rst_evt) begin
          state_d = ST_RUN; // RULE9
        end else if (brk_take) begin
          state_d  = ST_RUN; // RULE9
          brk_exit = 1'b1;
        end else if (irq_hit) begin
          state_d   = ST_RECOV; // RULE9
          wake_stop = 1'b1;
        end
      end
      ST_RECOV: begin
        if (rst_evt) begin
          state_d = ST_RUN;
        end else if (brk_take) begin
          state_d = ST_RUN;
        end else if (rec.done) begin
          state_d = ST_RUN; // RULE9
          rec_fin = 1'b1;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_RUN;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  // ------------------------------
  // Stop recovery counter
  // ------------------------------
  // Crystal systems are expected to leave the short setting clear
  assign rec.start     = rec_start_q;
  assign rec.short_sel = cfg_q[CFG_SHORT_REC]; // RULE10 RULE11
  assign rec.tick      = quad_osc_tick;

  lprs_recovery #(
    .LONG_CNT  (LONG_CNT),
    .SHORT_CNT (SHORT_CNT)
  ) u_recovery (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .rec     (rec.cnt)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_start_q <= 1'b0;
    end else if (clk_en) begin
      rec_start_q <= wake_stop; // RULE9
    end
  end

  // ------------------------------
  // Stacking request
  // ------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_pend_q   <= 1'b0;
      stack_start_q <= 1'b0;
    end else if (clk_en) begin
      wake_pend_q   <= wake_wait;
      stack_start_q <= wake_pend_q || rec_fin; // RULE5 RULE9
    end
  end

  // ------------------------------
  // Clock gating and side outputs
  // ------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clk_en_q     <= 1'b1;
      per_clk_en_q     <= 1'b1;
      osc_en_q         <= 1'b1;
      imask_clr_q      <= 1'b0;
      sys_cnt_rst_q    <= 1'b0;
      watchdog_run_q   <= 1'b0;
      flag_clear_ok_q  <= 1'b1;
      two_step_clear_q <= 1'b0;
    end else if (clk_en) begin
      cpu_clk_en_q     <= (state_d == ST_RUN); // RULE1 RULE3
      per_clk_en_q     <= (state_d == ST_RUN) || (state_d == ST_WAIT); // RULE3
      osc_en_q         <= (state_d == ST_RUN) || (state_d == ST_WAIT); // RULE8
      imask_clr_q      <= enter_lp; // RULE2
      sys_cnt_rst_q    <= enter_stop; // RULE8
      watchdog_run_q   <= !cfg_q[CFG_WDOG_DIS] &&
                          ((state_d == ST_RUN) || (state_d == ST_WAIT)); // RULE7
      flag_clear_ok_q  <= clear_ok; // RULE21
      two_step_clear_q <= step2_pulse && armed_q && clear_ok; // RULE22
    end
  end

  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign cpu_clk_en      = cpu_clk_en_q;
  assign per_clk_en      = per_clk_en_q;
  assign dbl_osc_clk_en  = osc_en_q;
  assign quad_osc_clk_en = osc_en_q;
  assign imask_clr       = imask_clr_q;
  assign stack_start     = stack_start_q;
  assign sys_cnt_rst     = sys_cnt_rst_q;
  assign watchdog_run    = watchdog_run_q;
  assign break_active    = break_q;
  assign flag_clear_ok   = flag_clear_ok_q;
  assign two_step_clear  = two_step_clear_q;
  assign low_power_state = state_q;
endmodule : lprs_top

`default_nettype wire

// file: test/lprs_cpu_model.sv
// CPU core and oscillator stand-in on the far side of the sequencer
`default_nettype none

module lprs_cpu_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       cpu_clk_en,
  input  wire logic       do_wait,
  input  wire logic       do_stop,
  input  wire logic [1:0] tick_div,
  output logic            wait_instr,
  output logic            stop_instr,
  output logic            quad_osc_tick
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div_q;
  // An unclocked CPU cannot execute an instruction
  assign wait_instr = do_wait & cpu_clk_en;
  assign stop_instr = do_stop & cpu_clk_en;
  // One tick every tick_div+1 cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 2'h0;
    end else begin
      div_q <= (div_q >= tick_div) ? 2'h0 : div_q + 2'h1;
    end
  end
  assign quad_osc_tick = (div_q == 2'h0);
endmodule : lprs_cpu_model

`default_nettype wire

// file: test/lprs_top_checker.sv
// Concurrent checks on the low-power sequencer ports
`default_nettype none

module lprs_top_checker
  import lprs_pkg::*;
#(
  parameter int unsigned IRQ_N     = 8,
  parameter int unsigned LONG_CNT  = RECOV_LONG,
  parameter int unsigned SHORT_CNT = RECOV_SHORT
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              clk_en,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic              pready,
  input wire logic              wait_instr,
  input wire logic              stop_instr,
  input wire logic [IRQ_N-1:0]  irq_req,
  input wire logic [IRQ_N-1:0]  irq_en,
  input wire logic              brk_req,
  input wire logic              emul_mode,
  input wire logic              quad_osc_tick,
  input wire logic              step2_pulse,
  input wire logic              cpu_clk_en,
  input wire logic              per_clk_en,
  input wire logic              quad_osc_clk_en,
  input wire logic              imask_clr,
  input wire logic              stack_start,
  input wire logic              sys_cnt_rst,
  input wire logic              watchdog_run,
  input wire logic              break_active,
  input wire logic              flag_clear_ok,
  input wire logic              two_step_clear,
  input wire logic [1:0]        low_power_state
);
  logic [1:0]  cfg_q;
  logic        bfc_q;
  logic        sel_q;
  int unsigned tcnt_q;
  wire logic [1:0] lps   = low_power_state;
  wire logic       wake  = |(irq_req & irq_en);
  wire logic       wr_ok = psel && penable && pready && pwrite;
  wire logic [31:0] lo   = sel_q ? SHORT_CNT : LONG_CNT;
  // ----------------------------------------
  // Shadow of the writable control bits
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= CFG_RESET;
      bfc_q <= BFC_RESET;
    end else if (wr_ok) begin
      if (paddr == OFS_CFG) cfg_q <= pwdata[1:0];
      if (paddr == OFS_BFC) bfc_q <= pwdata[BFC_CLR_EN];
    end
  end
  // Short select is frozen once recovery starts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q  <= 1'b0;
      tcnt_q <= 0;
    end else begin
      if (lps != 2'b11) sel_q <= cfg_q[CFG_SHORT_REC];
      if (lps != 2'b11) tcnt_q <= 0;
      else if (quad_osc_tick && clk_en) tcnt_q <= tcnt_q + 1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wait_entry_a: assert property (
    lps == 2'b00 && wait_instr && !stop_instr && clk_en && !brk_req
    |=> lps == 2'b01 && !cpu_clk_en && per_clk_en && imask_clr) else $error("wait entry");
  stop_entry_a: assert property (
    lps == 2'b00 && stop_instr && clk_en && !brk_req
    |=> lps == 2'b10 && !per_clk_en && sys_cnt_rst && imask_clr) else $error("stop entry");
  wait_wake_a: assert property (
    lps == 2'b01 && wake && !brk_req && clk_en
    |=> lps == 2'b00 && cpu_clk_en ##1 stack_start) else $error("wait wake");
  stop_gated_a: assert property (
    lps[1] |-> !cpu_clk_en && !quad_osc_clk_en) else $error("stop clocks");
  recov_len_a: assert property (
    $past(lps) == 2'b11 && lps == 2'b00 |-> stack_start && tcnt_q >= lo && tcnt_q <= lo + 2)
    else $error("recovery length");
  wait_brk_a: assert property (
    lps == 2'b01 && brk_req && emul_mode && clk_en |=> lps == 2'b00 && break_active)
    else $error("break in wait");
  wdog_run_a: assert property (
    lps == 2'b01 && !cfg_q[CFG_WDOG_DIS] |-> watchdog_run) else $error("watchdog stopped");
  clear_ok_a: assert property (
    flag_clear_ok == (!$past(break_active) || $past(bfc_q))) else $error("clear enable");
  protect_a: assert property (
    step2_pulse && !flag_clear_ok && !$past(flag_clear_ok) |=> !two_step_clear)
    else $error("protected clear");
  wake_c: cover property (lps == 2'b01 ##1 lps == 2'b00);
  recov_c: cover property (lps == 2'b11 ##1 lps == 2'b00);
  clear_c: cover property (two_step_clear);
endmodule : lprs_top_checker

bind lprs_top lprs_top_checker #(.IRQ_N(IRQ_N), .LONG_CNT(LONG_CNT), .SHORT_CNT(SHORT_CNT))
  chk_u (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .wait_instr, .stop_instr, .irq_req, .irq_en, .brk_req, .emul_mode, .quad_osc_tick,
  .step2_pulse, .cpu_clk_en, .per_clk_en, .quad_osc_clk_en, .imask_clr, .stack_start,
  .sys_cnt_rst, .watchdog_run, .break_active, .flag_clear_ok, .two_step_clear,
  .low_power_state);

`default_nettype wire

// file: test/test_lprs_top.sv
// Self-checking bench for the low-power sequencer and reset status block
`default_nettype none

module test_lprs_top;
  timeunit 1ns;
  timeprecision 1ns;
  import lprs_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr, irq_req, irq_en;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0]  rst_src;
  logic [1:0]  lps, tdiv;
  logic        brk_req, brk_done, emul, step1, step2, do_wait, do_stop, tick, wi, si;
  logic        cpu_en, per_en, quad_en, stack, two, brk_act, clr_ok, wdog, dbl;
  int          n_fail, n_checks, cyc, n_stack, n_two, n_tick;

  lprs_top #(.LONG_CNT(16), .SHORT_CNT(4)) dut_u (.pclk, .presetn, .clk_en(1'b1), .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .wait_instr(wi),
    .stop_instr(si), .irq_req, .irq_en, .brk_req, .brk_done, .emul_mode(emul),
    .quad_osc_tick(tick), .rst_src, .step1_pulse(step1), .step2_pulse(step2),
    .cpu_clk_en(cpu_en), .per_clk_en(per_en), .dbl_osc_clk_en(dbl), .quad_osc_clk_en(quad_en),
    .imask_clr(), .stack_start(stack), .sys_cnt_rst(), .watchdog_run(wdog),
    .break_active(brk_act), .flag_clear_ok(clr_ok), .two_step_clear(two), .low_power_state(lps));
  lprs_cpu_model cpu_u (.pclk, .presetn, .cpu_clk_en(cpu_en), .do_wait, .do_stop,
    .tick_div(tdiv), .wait_instr(wi), .stop_instr(si), .quad_osc_tick(tick));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // --------------------------------
  // Event counters and hang guard
  // --------------------------------
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (stack === 1'b1) n_stack <= n_stack + 1;
    if (two === 1'b1) n_two <= n_two + 1;
    if (lps === 2'b11 && tick === 1'b1) n_tick <= n_tick + 1;
    if (cyc > 20000) begin
      n_fail = n_fail + 1;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (n_fail == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  task automatic src(input logic [6:0] v);
    rst_src <= v;
    repeat (5) @(posedge pclk);
    rst_src <= 7'h00;
    repeat (2) @(posedge pclk);
  endtask : src

  task automatic go_lp(input logic stop);
    if (stop) do_stop <= 1'b1;
    else do_wait <= 1'b1;
    @(posedge pclk);
    do_stop <= 1'b0;
    do_wait <= 1'b0;
  endtask : go_lp

  task automatic wait_lps(input logic [1:0] s);
    while (lps !== s) @(posedge pclk);
    chk(lps, s);
  endtask : wait_lps

  initial begin
    {psel, penable, pwrite, brk_req, brk_done, emul, step1, step2, do_wait, do_stop} = '0;
    {paddr, irq_req, irq_en, rst_src, pwdata, tdiv, presetn} = '0;
    {n_fail, n_checks, cyc, n_stack, n_two, n_tick} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(OFS_RSR, 32'h01);
    rdchk(OFS_RSR, 32'h00);
    for (int b = 1; b < 7; b++) begin
      src(7'h01 << b);
      rdchk(OFS_RSR, 32'h1 << b);
    end
    src(7'h04);
    src(7'h40);
    rdchk(OFS_RSR, 32'h44);
    src(7'h02);
    src(7'h01);
    rdchk(OFS_RSR, 32'h01);
    apb(1'b1, OFS_RSR, 32'h7f);
    rdchk(OFS_RSR, 32'h00);
    apb(1'b1, OFS_BFC, 32'hffffffff);
    rdchk(OFS_BFC, 32'h1);
    apb(1'b1, OFS_BFC, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk(er, 1'b1);
    // Arm a two-step clear before any break
    step1 <= 1'b1;
    @(posedge pclk);
    step1 <= 1'b0;
    irq_req <= 8'h08;
    go_lp(1'b0);
    wait_lps(2'b01);
    chk({cpu_en, per_en, wdog}, 3'b011);
    repeat (20) @(posedge pclk);
    chk(lps, 2'b01);
    irq_en <= 8'h08;
    wait_lps(2'b00);
    repeat (2) @(posedge pclk);
    chk(n_stack, 1);
    irq_req <= 8'h00;
    for (int s = 0; s < 2; s++) begin
      // Short recovery only with fast oscillators
      apb(1'b1, OFS_CFG, s ? 32'h2 : 32'h0);
      tdiv <= s ? 2'h0 : 2'h2;
      go_lp(1'b1);
      wait_lps(2'b10);
      chk({per_en, quad_en, dbl}, 3'b000);
      n_tick = 0;
      irq_req <= 8'h08;
      wait_lps(2'b11);
      wait_lps(2'b00);
      chk(n_tick >= (s ? 4 : 16) && n_tick <= (s ? 6 : 18), 1'b1);
      irq_req <= 8'h00;
    end
    emul <= 1'b1;
    go_lp(1'b0);
    wait_lps(2'b01);
    brk_req <= 1'b1;
    @(posedge pclk);
    brk_req <= 1'b0;
    wait_lps(2'b00);
    chk(brk_act, 1'b1);
    rdchk(OFS_BSR, 32'h1);
    chk(clr_ok, 1'b0);
    step2 <= 1'b1;
    @(posedge pclk);
    step2 <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(n_two, 0);
    apb(1'b1, OFS_BFC, 32'h1);
    repeat (2) @(posedge pclk);
    chk(clr_ok, 1'b1);
    apb(1'b1, OFS_BFC, 32'h0);
    brk_done <= 1'b1;
    @(posedge pclk);
    brk_done <= 1'b0;
    repeat (2) @(posedge pclk);
    step2 <= 1'b1;
    @(posedge pclk);
    step2 <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(n_two, 1);
    end_of_test();
  end
endmodule : test_lprs_top

`default_nettype wire
